// >>> verilog/kbd_irq_pkg.sv
// constants shared by the keyboard pin interrupt block
// Behaviour
// - eight pin enable bits; a cleared bit makes its pin ignored
// - polarity bit per pin: 0 falling/low, 1 rising/high
// - up to eight pins combine into one shared interrupt flag
// - one detection mode bit applies to all enabled pins together
// - falling polarity: sampled 1 then 0 on next cycle is an edge
// - rising polarity: sampled 0 then 1 on next cycle is an edge
// - new edge only after all enabled inputs were deasserted
// - edge only mode: valid edge on an enabled pin sets flag
// - flag set with interrupt enable 1 requests a processor interrupt
// - writing 1 to acknowledge clears the flag
// - edge and level mode: edge or asserted level sets the flag
// - edge and level mode: acknowledge clears only if all deasserted
// - enabled pull resistor: polarity 0 pull-up, 1 pull-down on a pin whose enable bit is set, else pull-up
// - with interrupt enable 1, enabled inputs serve as wake-up source from wait and stop
// - detection mode 0 edge only, 1 edge and level
// - flag is read-only; writes to its position do nothing
// - acknowledge bit stores nothing and reads as zero
// - interrupt enable 0 suppresses request, 1 permits it
package kbd_irq_pkg;

   // register bus geometry
   localparam int           DATA_W             = 8;
   localparam int           ADDR_W             = 2;
   localparam int           MAX_PINS           = 8;
   localparam int           SYNC_STAGES        = 2;

   // register addresses
   localparam logic [1:0]   ADDR_STATUS_CTRL   = 2'h0;
   localparam logic [1:0]   ADDR_PIN_ENABLE    = 2'h1;
   localparam logic [1:0]   ADDR_POLARITY      = 2'h2;

   // status_control_reg field positions
   localparam int           BIT_DETECT_MODE    = 0;
   localparam int           BIT_IRQ_ENABLE     = 1;
   localparam int           BIT_ACKNOWLEDGE    = 2;
   localparam int           BIT_FLAG           = 3;

   // detection modes
   localparam logic         MODE_EDGE_ONLY     = 1'b0;
   localparam logic         MODE_EDGE_LEVEL    = 1'b1;

   // reset values
   localparam logic [7:0]   RESET_PIN_ENABLE   = 8'h00;
   localparam logic [7:0]   RESET_POLARITY     = 8'h00;
   localparam logic         RESET_DETECT_MODE  = 1'b0;
   localparam logic         RESET_IRQ_ENABLE   = 1'b0;
   localparam logic         RESET_FLAG         = 1'b0;
   localparam logic [7:0]   READ_ZERO          = 8'h00;

endpackage : kbd_irq_pkg

// >>> verilog/pin_sync.sv
// two-stage synchroniser for a group of input pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH  = 8
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   // pins in, synchronised copy out
   input  wire logic [WIDTH-1:0]  pin_raw,
   output logic      [WIDTH-1:0]  pin_synced
);

   logic [WIDTH-1:0] stage_one;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("pin_sync needs at least one pin");
      end
   endgenerate

   // stage_one feeds only the second flop, never any logic
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage_one  <= '0;
         pin_synced <= '0;
      end else begin
         stage_one  <= pin_raw;
         pin_synced <= stage_one;
      end
   end

endmodule : pin_sync

// >>> verilog/keyboard_pin_interrupt.sv
// keyboard pin interrupt: eight pins, one shared flag and request
`timescale 1ns/1ps
module keyboard_pin_interrupt #(
   parameter int NUM_PINS = 8
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   // register port
   input  wire logic [1:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   output logic      [7:0]           reg_rdata,
   // external interrupt inputs
   input  wire logic [NUM_PINS-1:0]  interrupt_input_pin,
   // pad resistor control
   input  wire logic [NUM_PINS-1:0]  port_pull_enable,
   output logic      [NUM_PINS-1:0]  pull_up_enable,
   output logic      [NUM_PINS-1:0]  pull_down_enable,
   // requests to the processor and power control
   output logic                      irq_request,
   output logic                      wake_request,
   output logic                      shared_irq_flag
);

   // pins beyond NUM_PINS are never writable and read as zero
   localparam logic [8:0] PIN_ONE  = 9'h001;
   localparam logic [7:0] PIN_MASK =
      8'((PIN_ONE << NUM_PINS) - PIN_ONE);

   generate
      if (NUM_PINS < 1 || NUM_PINS > kbd_irq_pkg::MAX_PINS) begin : g_bad
         $error("keyboard_pin_interrupt supports one to eight pins");
      end
   endgenerate

   // the register layout lives in the package; an edit there that the
   // decode and readback below cannot serve is refused here
   localparam bit FIELD_OUTSIDE =
      kbd_irq_pkg::BIT_DETECT_MODE >= kbd_irq_pkg::DATA_W ||
      kbd_irq_pkg::BIT_IRQ_ENABLE  >= kbd_irq_pkg::DATA_W ||
      kbd_irq_pkg::BIT_ACKNOWLEDGE >= kbd_irq_pkg::DATA_W ||
      kbd_irq_pkg::BIT_FLAG        >= kbd_irq_pkg::DATA_W;
   // two fields on one bit would let an ack write also change the mode
   localparam bit FIELD_CLASH =
      kbd_irq_pkg::BIT_DETECT_MODE == kbd_irq_pkg::BIT_IRQ_ENABLE  ||
      kbd_irq_pkg::BIT_DETECT_MODE == kbd_irq_pkg::BIT_ACKNOWLEDGE ||
      kbd_irq_pkg::BIT_DETECT_MODE == kbd_irq_pkg::BIT_FLAG        ||
      kbd_irq_pkg::BIT_IRQ_ENABLE  == kbd_irq_pkg::BIT_ACKNOWLEDGE ||
      kbd_irq_pkg::BIT_IRQ_ENABLE  == kbd_irq_pkg::BIT_FLAG        ||
      kbd_irq_pkg::BIT_ACKNOWLEDGE == kbd_irq_pkg::BIT_FLAG;
   localparam bit ADDR_CLASH =
      kbd_irq_pkg::ADDR_STATUS_CTRL == kbd_irq_pkg::ADDR_PIN_ENABLE ||
      kbd_irq_pkg::ADDR_STATUS_CTRL == kbd_irq_pkg::ADDR_POLARITY   ||
      kbd_irq_pkg::ADDR_PIN_ENABLE  == kbd_irq_pkg::ADDR_POLARITY;

   generate
      if (kbd_irq_pkg::DATA_W != $bits(reg_wdata)) begin : g_bad_data_w
         $error("package data width differs from the register port");
      end
      if (kbd_irq_pkg::ADDR_W != $bits(reg_addr)) begin : g_bad_addr_w
         $error("package address width differs from the register port");
      end
      if (kbd_irq_pkg::MAX_PINS > kbd_irq_pkg::DATA_W) begin : g_bad_max
         $error("more pins than bits in one register");
      end
      if (FIELD_OUTSIDE) begin : g_bad_pos
         $error("a control field lies outside the status register");
      end
      if (FIELD_CLASH) begin : g_dup_bit
         $error("two control fields share one bit");
      end
      if (ADDR_CLASH) begin : g_dup_addr
         $error("two registers share one address");
      end
      // pins beyond NUM_PINS must come out of reset at zero as well
      if ((kbd_irq_pkg::RESET_PIN_ENABLE & ~PIN_MASK) != '0 ||
          (kbd_irq_pkg::RESET_POLARITY & ~PIN_MASK) != '0) begin : g_bad_rst
         $error("reset value sets a pin beyond NUM_PINS");
      end
   endgenerate

   // ---- register state
   logic [7:0]           pin_enable_reg;
   logic [7:0]           polarity_select_reg;
   logic                 detect_mode_bit;
   logic                 irq_enable_bit;

   // ---- pin sampling
   logic [NUM_PINS-1:0]  pin_now;
   logic [NUM_PINS-1:0]  pin_prev;
   logic [NUM_PINS-1:0]  pin_enable_bit;
   logic [NUM_PINS-1:0]  pin_polarity_bit;
   logic [NUM_PINS-1:0]  asserted_now;
   logic [NUM_PINS-1:0]  asserted_prev;
   logic [NUM_PINS-1:0]  pin_edge;

   // ---- detection
   logic                 armed;
   logic                 all_deasserted;
   logic                 any_asserted;
   logic                 edge_seen;
   logic                 level_seen;
   logic                 flag_set;
   logic                 flag_acknowledge;
   logic                 flag_clear;
   logic                 next_flag;
   logic [7:0]           status_control_reg;
   logic [7:0]           next_rdata;

   // ---- bus decode
   logic                 write_status;
   logic                 write_enable;
   logic                 write_polarity;

   assign write_status   = reg_write &&
                           reg_addr == kbd_irq_pkg::ADDR_STATUS_CTRL;
   assign write_enable   = reg_write &&
                           reg_addr == kbd_irq_pkg::ADDR_PIN_ENABLE;
   assign write_polarity = reg_write &&
                           reg_addr == kbd_irq_pkg::ADDR_POLARITY;

   // acknowledge is a pure strobe, nothing of it is stored
   assign flag_acknowledge =
      write_status && reg_wdata[kbd_irq_pkg::BIT_ACKNOWLEDGE];

   // ---- pin enable register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pin_enable_reg <= kbd_irq_pkg::RESET_PIN_ENABLE;
      end else if (write_enable) begin
         pin_enable_reg <= reg_wdata & PIN_MASK;
      end
   end

   // ---- polarity register, also steers the pad resistors
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         polarity_select_reg <= kbd_irq_pkg::RESET_POLARITY;
      end else if (write_polarity) begin
         polarity_select_reg <= reg_wdata & PIN_MASK;
      end
   end

   // ---- control bits; the flag position is ignored on write
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         detect_mode_bit <= kbd_irq_pkg::RESET_DETECT_MODE;
         irq_enable_bit  <= kbd_irq_pkg::RESET_IRQ_ENABLE;
      end else if (write_status) begin
         detect_mode_bit <=
            reg_wdata[kbd_irq_pkg::BIT_DETECT_MODE];
         irq_enable_bit  <=
            reg_wdata[kbd_irq_pkg::BIT_IRQ_ENABLE];
      end
   end

   // ---- synchroniser in front of the comparators
   pin_sync #(
      .WIDTH      (NUM_PINS)
   ) u_pin_sync (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .pin_raw    (interrupt_input_pin),
      .pin_synced (pin_now)
   );

   // one bus cycle of history for the edge compare
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pin_prev <= '0;
      end else begin
         pin_prev <= pin_now;
      end
   end

   // ---- per-pin sense; polarity turns each pin into "asserted"
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_pin
         assign pin_enable_bit[i]   = pin_enable_reg[i];
         assign pin_polarity_bit[i] = polarity_select_reg[i];
         // a disabled pin never counts as asserted
         assign asserted_now[i]  = pin_enable_bit[i] &&
            (pin_now[i] == pin_polarity_bit[i]);
         assign asserted_prev[i] = pin_enable_bit[i] &&
            (pin_prev[i] == pin_polarity_bit[i]);
         // deasserted one cycle, asserted the next
         assign pin_edge[i] =
            asserted_now[i] && !asserted_prev[i];
      end
   endgenerate

   assign any_asserted   = |asserted_now;
   assign all_deasserted = !any_asserted;

   // ---- rearm: after an edge every enabled pin must go quiet again
   // the arm starts cleared so a pin already asserted at reset
   // release does not count as a first edge
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         armed <= 1'b0;
      end else if (edge_seen) begin
         armed <= 1'b0;
      end else if (all_deasserted) begin
         armed <= 1'b1;
      end
   end

   assign edge_seen  = armed && (|pin_edge);
   assign level_seen = (detect_mode_bit == kbd_irq_pkg::MODE_EDGE_LEVEL)
                       && any_asserted;
   assign flag_set   = edge_seen || level_seen;

   // in edge and level mode an asserted pin blocks the clear
   assign flag_clear = flag_acknowledge &&
      ((detect_mode_bit == kbd_irq_pkg::MODE_EDGE_ONLY) ||
       all_deasserted);

   // a set in the clearing cycle wins so no event is lost
   always_comb begin
      if (flag_set) begin
         next_flag = 1'b1;
      end else if (flag_clear) begin
         next_flag = 1'b0;
      end else begin
         next_flag = shared_irq_flag;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         shared_irq_flag <= kbd_irq_pkg::RESET_FLAG;
      end else begin
         shared_irq_flag <= next_flag;
      end
   end

   // ---- request built from the next flag so it tracks it exactly
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= next_flag && irq_enable_bit;
      end
   end

   // wake also follows a synchronised asserted pin, since in low power the
   // flag path may be held off until the clocks come back
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= irq_enable_bit &&
                         (next_flag || any_asserted);
      end
   end

   // ---- pad resistors: polarity flips pull-up to pull-down only
   // for pins working as interrupt inputs
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pull_up_enable   <= '0;
         pull_down_enable <= '0;
      end else begin
         pull_up_enable   <= port_pull_enable &
                             ~(pin_enable_bit & pin_polarity_bit);
         pull_down_enable <= port_pull_enable &
                             pin_enable_bit & pin_polarity_bit;
      end
   end

   // ---- readback
   always_comb begin
      status_control_reg = kbd_irq_pkg::READ_ZERO;
      status_control_reg[kbd_irq_pkg::BIT_DETECT_MODE] = detect_mode_bit;
      status_control_reg[kbd_irq_pkg::BIT_IRQ_ENABLE]  = irq_enable_bit;
      status_control_reg[kbd_irq_pkg::BIT_FLAG]        = shared_irq_flag;
   end

   always_comb begin
      next_rdata = kbd_irq_pkg::READ_ZERO;
      if (reg_read) begin
         case (reg_addr)
            kbd_irq_pkg::ADDR_STATUS_CTRL: begin
               next_rdata = status_control_reg;
            end
            kbd_irq_pkg::ADDR_PIN_ENABLE: begin
               next_rdata = pin_enable_reg;
            end
            kbd_irq_pkg::ADDR_POLARITY: begin
               next_rdata = polarity_select_reg;
            end
            default: begin
               next_rdata = kbd_irq_pkg::READ_ZERO;
            end
         endcase
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata <= kbd_irq_pkg::READ_ZERO;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : keyboard_pin_interrupt

// >>> sim/key_sources.sv
// model of the external switch rows driving the interrupt pins
`timescale 1ns/1ps
module key_sources (
   // clock
   input  wire logic       core_clk,
   // commanded levels, pin levels
   input  wire logic [7:0] want,
   output logic      [7:0] pins
);
   // switches move only just after an edge, like clean debounced keys
   always @(posedge core_clk) pins <= want;
endmodule : key_sources

// >>> sim/kbd_irq_asserts.sv
// port checker for the keyboard pin interrupt block
`timescale 1ns/1ps
module kbd_irq_asserts #(
   parameter int N = 8
) (
   // clock, reset, register port
   input wire logic         core_clk,
   input wire logic         reset_n,
   input wire logic [1:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic         reg_write,
   input wire logic         reg_read,
   input wire logic [7:0]   reg_rdata,
   // pads and requests
   input wire logic [N-1:0] port_pull_enable,
   input wire logic [N-1:0] pull_up_enable,
   input wire logic [N-1:0] pull_down_enable,
   input wire logic         irq_request,
   input wire logic         wake_request,
   input wire logic         shared_irq_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rd0;
      reg_read && reg_addr == 2'h0;
   endsequence
   property p_irq; irq_request |-> shared_irq_flag; endproperty
   property p_wake; irq_request |-> wake_request; endproperty
   property p_pex; (pull_up_enable & pull_down_enable) == '0; endproperty
   property p_psrc;
      $past(reset_n) |->
         (pull_up_enable | pull_down_enable) == $past(port_pull_enable);
   endproperty
   property p_clr;
      $fell(shared_irq_flag) |->
         $past(reg_write && reg_addr == 2'h0 && reg_wdata[2]);
   endproperty
   property p_rd0; s_rd0 |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2];
   endproperty
   property p_rdf; s_rd0 |=> reg_rdata[3] == $past(shared_irq_flag);
   endproperty
   property p_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
   a_irq: assert property (p_irq) else $error("irq without flag");
   a_wake: assert property (p_wake) else $error("no wake");
   a_pex: assert property (p_pex) else $error("both pulls on");
   a_psrc: assert property (p_psrc) else $error("pull mismatch");
   a_clr: assert property (p_clr) else $error("flag fell alone");
   a_rd0: assert property (p_rd0) else $error("ctrl read bits");
   a_rdf: assert property (p_rdf) else $error("flag read");
   a_idle: assert property (p_idle) else $error("rdata not idle");
endmodule : kbd_irq_asserts
bind keyboard_pin_interrupt kbd_irq_asserts #(.N(NUM_PINS)) u_chk (.*);

// >>> sim/keyboard_pin_interrupt_tb.sv
// self-checking bench for the keyboard pin interrupt block
`timescale 1ns/1ps
module keyboard_pin_interrupt_tb;
   logic       core_clk = 1'b0;
   logic       reset_n  = 1'b0;
   logic [1:0] ra       = 2'h0;
   logic [7:0] wd       = 8'h00;
   logic       we       = 1'b0;
   logic       re       = 1'b0;
   logic [7:0] rdata;
   logic [7:0] want     = 8'hff;
   logic [7:0] pins;
   logic [7:0] ppe      = 8'h00;
   logic [7:0] pu;
   logic [7:0] pd;
   logic       irq;
   logic       wake;
   logic       flag;
   int         n_fail   = 0;
   int         n_checks = 0;
   always #2 core_clk = ~core_clk;
   key_sources u_key_sources (.core_clk(core_clk), .want(want), .pins(pins));
   keyboard_pin_interrupt u_keyboard_pin_interrupt (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(ra),
      .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata(rdata),
      .interrupt_input_pin(pins), .port_pull_enable(ppe),
      .pull_up_enable(pu), .pull_down_enable(pd), .irq_request(irq),
      .wake_request(wake), .shared_irq_flag(flag));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk1(input string nm, input logic e, g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle
   // each call starts on an edge, so strobes never move off the edge
   // and back-to-back calls keep a one-cycle gap between strobes
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      ra <= a; wd <= d; we <= 1'b1;
      @(posedge core_clk); we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge core_clk);
      ra <= a; re <= 1'b1;
      @(posedge core_clk); re <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask : rd
   task automatic setup(input logic [7:0] c, p, e, l);
      wr(2'h0, c & 8'h01);
      wr(2'h2, p);
      want <= l;
      settle(6);
      wr(2'h1, e);
      wr(2'h0, (c & 8'h01) | 8'h04);
      wr(2'h0, c);
   endtask : setup
   task automatic t_regs;
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h1, 8'hff);
      rd(2'h1, 8'hff);
      wr(2'h2, 8'ha5);
      rd(2'h2, 8'ha5);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h00);
      wr(2'h1, 8'h00);
      wr(2'h0, 8'h0d);
      rd(2'h0, 8'h01);
   endtask : t_regs
   task automatic t_fall;
      setup(8'h02, 8'h00, 8'h03, 8'hff);
      want <= 8'hfe;
      settle(6);
      chk1("flag", 1'b1, flag);
      chk1("irq", 1'b1, irq);
      wr(2'h0, 8'h06);
      settle(1);
      chk1("flag", 1'b0, flag);
      want <= 8'hfc;
      settle(6);
      chk1("flag", 1'b0, flag);
      want <= 8'hfb;
      settle(6);
      chk1("flag", 1'b0, flag);
      want <= 8'hfd;
      settle(6);
      chk1("flag", 1'b1, flag);
   endtask : t_fall
   task automatic t_rise;
      setup(8'h00, 8'h01, 8'h01, 8'h00);
      ppe <= 8'hff;
      want <= 8'h01;
      settle(6);
      chk("pull_dn", 8'h01, pd);
      chk("pull_up", 8'hfe, pu);
      chk1("flag", 1'b1, flag);
      chk1("irq", 1'b0, irq);
      chk1("wake", 1'b0, wake);
      wr(2'h0, 8'h02);
      settle(1);
      chk1("irq", 1'b1, irq);
   endtask : t_rise
   task automatic t_level;
      setup(8'h03, 8'h01, 8'h01, 8'h00);
      want <= 8'h01;
      settle(6);
      chk1("flag", 1'b1, flag);
      chk1("wake", 1'b1, wake);
      wr(2'h0, 8'h07);
      settle(1);
      chk1("flag", 1'b1, flag);
      want <= 8'h00;
      settle(6);
      wr(2'h0, 8'h07);
      settle(1);
      chk1("flag", 1'b0, flag);
   endtask : t_level
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_fall();
      t_rise();
      t_level();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      wrap_up();
   end
endmodule : keyboard_pin_interrupt_tb
